//--- hdl/dsgp_pin_sync.sv
// Three-stage pin input synchroniser with power-down input cut-off
`timescale 1ns/1ns
`default_nettype none
module dsgp_pin_sync
    import dsgp_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rst_in,
    dsgp_sync_if.sync sync_port
);
    logic [DSGP_PIN_COUNT-1:0] stage_one;
    logic [DSGP_PIN_COUNT-1:0] stage_two;
    logic [DSGP_PIN_COUNT-1:0] stage_three;
    logic [DSGP_PIN_COUNT-1:0] level;
    logic [DSGP_PIN_COUNT-1:0] next_stage_one;
    logic [DSGP_PIN_COUNT-1:0] next_stage_two;
    logic [DSGP_PIN_COUNT-1:0] next_stage_three;
    logic [DSGP_PIN_COUNT-1:0] next_level;

    ////////////////////////////////////////////////////////////////////////
    // Shift chain; the cut-off gate sits before the first flop so no analog
    // level near mid-supply reaches a digital receiver in power-down
    always_comb
    begin
        next_stage_one = sync_port.input_cut ? '0 : sync_port.raw;
        next_stage_two = stage_one;
        next_stage_three = stage_two;
    end

    // A change is taken only once the second and third stages agree
    for (genvar i = 0; i < DSGP_PIN_COUNT; i++)
    begin : g_level
        assign next_level[i] = (stage_two[i] == stage_three[i]) ? stage_three[i] : level[i];
    end

    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            stage_one <= '0;
            stage_two <= '0;
            stage_three <= '0;
            level <= '0;
        end
        else
        begin
            stage_one <= next_stage_one;
            stage_two <= next_stage_two;
            stage_three <= next_stage_three;
            level <= next_level;
        end
    end

    assign sync_port.level = level;
endmodule
`default_nettype wire

//--- hdl/dsgp_pkg.sv
// Constants shared by the dual six-bit port block
package dsgp_pkg;
    // Pins per port and total pins
    localparam int unsigned DSGP_PORT_WIDTH = 6;
    localparam int unsigned DSGP_PIN_COUNT = 12;
    // I/O-space address width and register data width
    localparam int unsigned DSGP_ADDR_WIDTH = 6;
    localparam int unsigned DSGP_DATA_WIDTH = 8;
    // First port register offsets
    localparam logic [5:0] DSGP_FIRST_OUTPUT_LATCH_OFFSET = 6'h18;
    localparam logic [5:0] DSGP_FIRST_DIRECTION_OFFSET = 6'h17;
    localparam logic [5:0] DSGP_FIRST_PIN_LEVELS_OFFSET = 6'h16;
    // Second port register offsets
    localparam logic [5:0] DSGP_SECOND_OUTPUT_LATCH_OFFSET = 6'h15;
    localparam logic [5:0] DSGP_SECOND_DIRECTION_OFFSET = 6'h14;
    localparam logic [5:0] DSGP_SECOND_PIN_LEVELS_OFFSET = 6'h13;
    // Reset values of the writable registers
    localparam logic [5:0] DSGP_OUTPUT_LATCH_RESET = 6'h00;
    localparam logic [5:0] DSGP_DIRECTION_RESET = 6'h00;
    // Value returned for unused upper bits and unmapped addresses
    localparam logic [1:0] DSGP_UPPER_BITS_READ = 2'h0;
    localparam logic [7:0] DSGP_UNMAPPED_READ = 8'h00;
    // First-port alternate function pin positions
    localparam int unsigned DSGP_CAPTURE_PIN = 0;
    localparam int unsigned DSGP_COMPARE_PIN = 1;
    localparam int unsigned DSGP_SPI_FIRST_PIN = 2;
    localparam int unsigned DSGP_SPI_PIN_COUNT = 4;
endpackage

//--- hdl/dsgp_ports.sv
// Two six-bit general-purpose I/O ports behind I/O-space registers
`timescale 1ns/1ns
`default_nettype none
module dsgp_ports
    import dsgp_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic [DSGP_ADDR_WIDTH-1:0] io_addr_in,
    input wire logic io_wr_in,
    input wire logic [DSGP_DATA_WIDTH-1:0] io_wdata_in,
    input wire logic io_rd_in,
    input wire logic io_bit_op_in,
    input wire logic [2:0] io_bit_index_in,
    input wire logic io_bit_value_in,
    output logic [DSGP_DATA_WIDTH-1:0] io_rdata_out,
    input wire logic power_down_in,
    input wire logic [DSGP_PORT_WIDTH-1:0] first_pin_in,
    output logic [DSGP_PORT_WIDTH-1:0] first_pin_out,
    output logic [DSGP_PORT_WIDTH-1:0] first_pin_oe_out,
    output logic [DSGP_PORT_WIDTH-1:0] first_pullup_out,
    input wire logic [DSGP_PORT_WIDTH-1:0] second_pin_in,
    output logic [DSGP_PORT_WIDTH-1:0] second_pin_out,
    output logic [DSGP_PORT_WIDTH-1:0] second_pin_oe_out,
    output logic [DSGP_PORT_WIDTH-1:0] second_pullup_out,
    input wire logic timer_compare_in,
    input wire logic timer_compare_en_in,
    input wire logic [DSGP_SPI_PIN_COUNT-1:0] spi_out_value_in,
    input wire logic [DSGP_SPI_PIN_COUNT-1:0] spi_out_en_in,
    output logic timer_capture_out,
    output logic [DSGP_SPI_PIN_COUNT-1:0] spi_in_level_out
);
    logic [DSGP_PORT_WIDTH-1:0] first_port_output_latch;
    logic [DSGP_PORT_WIDTH-1:0] first_port_direction;
    logic [DSGP_PORT_WIDTH-1:0] second_port_output_latch;
    logic [DSGP_PORT_WIDTH-1:0] second_port_direction;
    logic [DSGP_DATA_WIDTH-1:0] read_data;
    logic [DSGP_PORT_WIDTH-1:0] next_first_port_output_latch;
    logic [DSGP_PORT_WIDTH-1:0] next_first_port_direction;
    logic [DSGP_PORT_WIDTH-1:0] next_second_port_output_latch;
    logic [DSGP_PORT_WIDTH-1:0] next_second_port_direction;
    logic [DSGP_DATA_WIDTH-1:0] next_read_data;
    logic [DSGP_PORT_WIDTH-1:0] first_port_pin_levels;
    logic [DSGP_PORT_WIDTH-1:0] second_port_pin_levels;
    logic [DSGP_PORT_WIDTH-1:0] first_drive_value;

    dsgp_sync_if sync_bus ();

    ////////////////////////////////////////////////////////////////////////
    // Input path: all twelve pins share one synchroniser
    assign sync_bus.raw = {second_pin_in, first_pin_in};
    assign sync_bus.input_cut = power_down_in;

    dsgp_pin_sync u_pin_sync (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .sync_port(sync_bus.sync)
    );

    assign first_port_pin_levels = sync_bus.level[DSGP_PORT_WIDTH-1:0];
    assign second_port_pin_levels = sync_bus.level[DSGP_PIN_COUNT-1:DSGP_PORT_WIDTH];

    ////////////////////////////////////////////////////////////////////////
    // Register writes; a bit operation touches one bit, a byte write all six
    always_comb
    begin
        next_first_port_output_latch = first_port_output_latch;
        next_first_port_direction = first_port_direction;
        next_second_port_output_latch = second_port_output_latch;
        next_second_port_direction = second_port_direction;
        if (io_wr_in)
        begin
            // Pin-level offsets are not listed, so writes there fall away
            unique case (io_addr_in)
                DSGP_FIRST_OUTPUT_LATCH_OFFSET: next_first_port_output_latch = io_wdata_in[5:0];
                DSGP_FIRST_DIRECTION_OFFSET: next_first_port_direction = io_wdata_in[5:0];
                DSGP_SECOND_OUTPUT_LATCH_OFFSET: next_second_port_output_latch = io_wdata_in[5:0];
                DSGP_SECOND_DIRECTION_OFFSET: next_second_port_direction = io_wdata_in[5:0];
                default: ;
            endcase
        end
        else if (io_bit_op_in && (io_bit_index_in < 3'(DSGP_PORT_WIDTH)))
        begin
            // Index 6 and 7 name the unused upper bits and change nothing
            unique case (io_addr_in)
                DSGP_FIRST_OUTPUT_LATCH_OFFSET: next_first_port_output_latch[io_bit_index_in] = io_bit_value_in;
                DSGP_FIRST_DIRECTION_OFFSET: next_first_port_direction[io_bit_index_in] = io_bit_value_in;
                DSGP_SECOND_OUTPUT_LATCH_OFFSET: next_second_port_output_latch[io_bit_index_in] = io_bit_value_in;
                DSGP_SECOND_DIRECTION_OFFSET: next_second_port_direction[io_bit_index_in] = io_bit_value_in;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register reads; data is registered so it stands one cycle after the strobe
    always_comb
    begin
        next_read_data = read_data;
        if (io_rd_in)
        begin
            unique case (io_addr_in)
                DSGP_FIRST_OUTPUT_LATCH_OFFSET: next_read_data = {DSGP_UPPER_BITS_READ, first_port_output_latch};
                DSGP_FIRST_DIRECTION_OFFSET: next_read_data = {DSGP_UPPER_BITS_READ, first_port_direction};
                DSGP_FIRST_PIN_LEVELS_OFFSET: next_read_data = {DSGP_UPPER_BITS_READ, first_port_pin_levels};
                DSGP_SECOND_OUTPUT_LATCH_OFFSET: next_read_data = {DSGP_UPPER_BITS_READ, second_port_output_latch};
                DSGP_SECOND_DIRECTION_OFFSET: next_read_data = {DSGP_UPPER_BITS_READ, second_port_direction};
                DSGP_SECOND_PIN_LEVELS_OFFSET: next_read_data = {DSGP_UPPER_BITS_READ, second_port_pin_levels};
                default: next_read_data = DSGP_UNMAPPED_READ;
            endcase
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            first_port_output_latch <= DSGP_OUTPUT_LATCH_RESET;
            first_port_direction <= DSGP_DIRECTION_RESET;
            second_port_output_latch <= DSGP_OUTPUT_LATCH_RESET;
            second_port_direction <= DSGP_DIRECTION_RESET;
            read_data <= DSGP_UNMAPPED_READ;
        end
        else
        begin
            first_port_output_latch <= next_first_port_output_latch;
            first_port_direction <= next_first_port_direction;
            second_port_output_latch <= next_second_port_output_latch;
            second_port_direction <= next_second_port_direction;
            read_data <= next_read_data;
        end
    end

    assign io_rdata_out = read_data;

    ////////////////////////////////////////////////////////////////////////
    // First-port drive value: an enabled peripheral replaces the latch bit,
    // but direction stays with software so a wrong setup is visible at once
    always_comb
    begin
        first_drive_value = first_port_output_latch;
        if (timer_compare_en_in)
        begin
            first_drive_value[DSGP_COMPARE_PIN] = timer_compare_in;
        end
        for (int i = 0; i < DSGP_SPI_PIN_COUNT; i++)
        begin
            if (spi_out_en_in[i])
            begin
                first_drive_value[DSGP_SPI_FIRST_PIN + i] = spi_out_value_in[i];
            end
        end
    end

    // Pin drivers and per-pin pull-ups
    assign first_pin_out = first_drive_value;
    assign first_pin_oe_out = first_port_direction;
    assign first_pullup_out = ~first_port_direction & first_port_output_latch;
    assign second_pin_out = second_port_output_latch;
    assign second_pin_oe_out = second_port_direction;
    assign second_pullup_out = ~second_port_direction & second_port_output_latch;

    // Alternate function inputs come from the synchronised levels
    assign timer_capture_out = first_port_pin_levels[DSGP_CAPTURE_PIN];
    assign spi_in_level_out = first_port_pin_levels[DSGP_SPI_FIRST_PIN +: DSGP_SPI_PIN_COUNT];
endmodule
`default_nettype wire

//--- hdl/dsgp_sync_if.sv
// Interface between the port core and its input synchroniser
`timescale 1ns/1ns
`default_nettype none
interface dsgp_sync_if;
    import dsgp_pkg::*;
    logic [DSGP_PIN_COUNT-1:0] raw;
    logic input_cut;
    logic [DSGP_PIN_COUNT-1:0] level;
    modport core (output raw, output input_cut, input level);
    modport sync (input raw, input input_cut, output level);
endinterface
`default_nettype wire

//--- testbench/dsgp_pin_partner.sv
// Behavioural model of the circuits hanging on the twelve port pins
`timescale 1ns/1ns
`default_nettype none
module dsgp_pin_partner (
    input wire logic core_clk_in,
    input wire logic [11:0] oe_in,
    input wire logic [11:0] drive_in,
    input wire logic [11:0] pullup_in,
    input wire logic [11:0] ext_en_in,
    input wire logic [11:0] ext_val_in,
    output logic [11:0] level_out
);
    logic [11:0] float_q = 12'h000;
    // A floating pin wanders every cycle so a stale value never passes for a drive
    always_ff @(posedge core_clk_in)
    begin
        float_q <= ~float_q;
    end
    // The device driver wins, then the outside source, then the pull-up
    always_comb
    begin
        level_out = (oe_in & drive_in) | (~oe_in & ext_en_in & ext_val_in)
            | (~oe_in & ~ext_en_in & pullup_in) | (~oe_in & ~ext_en_in & ~pullup_in & float_q);
    end
endmodule
`default_nettype wire

//--- testbench/dsgp_ports_assertions.sv
// Concurrent checks on the register and pin behaviour of the dual port block
`timescale 1ns/1ns
`default_nettype none
module dsgp_ports_assertions (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic [5:0] io_addr_in,
    input wire logic io_wr_in,
    input wire logic [7:0] io_wdata_in,
    input wire logic io_rd_in,
    input wire logic io_bit_op_in,
    input wire logic [2:0] io_bit_index_in,
    input wire logic io_bit_value_in,
    input wire logic [7:0] io_rdata_out,
    input wire logic power_down_in,
    input wire logic [5:0] first_pin_in,
    input wire logic [5:0] first_pin_out,
    input wire logic [5:0] first_pin_oe_out,
    input wire logic [5:0] first_pullup_out,
    input wire logic [5:0] second_pin_oe_out,
    input wire logic timer_compare_in,
    input wire logic timer_compare_en_in,
    input wire logic timer_capture_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    // Direction writes reach the drive enables one edge later
    a_first_dir_write: assert property (
        io_wr_in && io_addr_in == 6'h17 |=> first_pin_oe_out == $past(io_wdata_in[5:0]))
        else $error("first direction write lost");
    a_second_dir_write: assert property (
        io_wr_in && io_addr_in == 6'h14 |=> second_pin_oe_out == $past(io_wdata_in[5:0]))
        else $error("second direction write lost");
    // A read returns the value held at the strobe edge, upper bits zero
    a_dir_read_back: assert property (
        io_rd_in && io_addr_in == 6'h17 |=> io_rdata_out == {2'h0, $past(first_pin_oe_out)})
        else $error("direction read back wrong");
    a_upper_bits_zero: assert property (io_rdata_out[7:6] == 2'h0)
        else $error("upper read bits not zero");
    // Writes to the pin-level place must not disturb the port set-up
    a_level_write_ignored: assert property (
        io_wr_in && io_addr_in == 6'h16 |=> $stable(first_pin_oe_out) && $stable(first_pullup_out))
        else $error("pin-level write changed the port");
    // A bit operation may only touch the addressed bit
    a_bit_op_local: assert property (
        io_bit_op_in && !io_wr_in && io_addr_in == 6'h17 && io_bit_index_in < 3'h6 |=>
        first_pin_oe_out == (($past(first_pin_oe_out) & ~(6'h01 << $past(io_bit_index_in)))
        | ({5'h00, $past(io_bit_value_in)} << $past(io_bit_index_in))))
        else $error("bit operation touched other bits");
    a_pullup_only_input: assert property ((first_pullup_out & first_pin_oe_out) == 6'h00)
        else $error("pull-up on a driven pin");
    // Synchroniser depth is three flops plus the level register
    a_power_down_cut: assert property (power_down_in [*5] |-> timer_capture_out == 1'b0)
        else $error("input not cut in power-down");
    a_capture_follows: assert property ((!power_down_in && first_pin_in[0]) [*5] |-> timer_capture_out)
        else $error("capture input not seen");
    a_compare_drive: assert property (
        timer_compare_en_in |-> first_pin_out[1] == timer_compare_in)
        else $error("compare output not on pin 1");
endmodule
bind dsgp_ports dsgp_ports_assertions u_chk (.*);
`default_nettype wire

//--- testbench/dsgp_ports_tb.sv
// Self-checking bench for the dual six-bit port block
`timescale 1ns/1ns
`default_nettype none
module dsgp_ports_tb;
    logic clk, rst, wr, rd, bop, bval, pd, tc, tce, cap;
    logic [5:0] addr, b, fout, foe, fpu, sout, soe, spu;
    logic [7:0] wdata, rdata, d, e;
    logic [2:0] bidx;
    logic [3:0] spv, spe, spil;
    logic [11:0] ext_en, ext_val, lvl;
    int n_errors = 0;
    int checks = 0;
    dsgp_ports dut (.core_clk_in(clk), .rst_in(rst), .io_addr_in(addr), .io_wr_in(wr), .io_wdata_in(wdata),
        .io_rd_in(rd), .io_bit_op_in(bop), .io_bit_index_in(bidx), .io_bit_value_in(bval), .io_rdata_out(rdata),
        .power_down_in(pd), .first_pin_in(lvl[5:0]), .first_pin_out(fout), .first_pin_oe_out(foe),
        .first_pullup_out(fpu), .second_pin_in(lvl[11:6]), .second_pin_out(sout), .second_pin_oe_out(soe),
        .second_pullup_out(spu), .timer_compare_in(tc), .timer_compare_en_in(tce), .spi_out_value_in(spv),
        .spi_out_en_in(spe), .timer_capture_out(cap), .spi_in_level_out(spil));
    dsgp_pin_partner u_pins (.core_clk_in(clk), .oe_in({soe, foe}), .drive_in({sout, fout}),
        .pullup_in({spu, fpu}), .ext_en_in(ext_en), .ext_val_in(ext_val), .level_out(lvl));
    ////////////////////////////////////////
    // 50 ns clock
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // One strobe per call; op is {write, read, bit}, bit ops take index v[2:0] and value v[7]
    task automatic bus(input logic [2:0] op, input logic [5:0] a, input logic [7:0] v);
        @(posedge clk);
        {wr, rd, bop} <= op;
        addr <= a;
        wdata <= v;
        bidx <= v[2:0];
        bval <= v[7];
        @(posedge clk);
        {wr, rd, bop} <= 3'h0;
        #1 d = rdata;
    endtask
    task automatic rdchk(input logic [5:0] a, input logic [7:0] exp);
        bus(3'h2, a, 8'h00);
        chk(d, exp);
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic end_sim;
        if (n_errors == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    ////////////////////////////////////////
    // Watchdog, far beyond the hundred or so cycles the tests need
    initial
    begin
        #200000;
        n_errors++;
        end_sim();
    end
    // Outside sources pull every released pin high
    initial
    begin
        {rst, wr, rd, bop, bval, pd, tc, tce} = 8'h80;
        {addr, wdata, bidx, spv, spe} = 25'h0;
        ext_en = 12'hFFF;
        ext_val = 12'hFFF;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        wt(4); // Pin levels need four edges to cross the synchroniser after reset
        for (int i = 0; i < 6; i++) rdchk(6'h13 + 6'(i), (i % 3 == 0) ? 8'h3F : 8'h00);
        chk({fpu, 2'h0} | {spu, 2'h0}, 8'h00);
        for (int p = 0; p < 2; p++)
        begin
            b = p ? 6'h13 : 6'h16;
            bus(3'h4, b + 6'h1, 8'hEA);
            bus(3'h4, b + 6'h2, 8'hF5);
            bus(3'h4, b, 8'h00);
            rdchk(b + 6'h1, 8'h2A);
            rdchk(b + 6'h2, 8'h35);
            rdchk(b, 8'h35);
        end
        chk(foe & soe, 6'h2A);
        chk(fpu & spu, 6'h15);
        chk((fout & foe) | (sout & soe), 6'h20);
        bus(3'h4, 6'h19, 8'hFF);
        rdchk(6'h19, 8'h00);
        e = 8'h2A;
        for (int i = 0; i < 8; i++)
        begin
            bus(3'h1, 6'h17, {!e[i], 4'h0, 3'(i)});
            if (i < 6) e[i] = !e[i];
            chk(foe, e);
        end
        bus(3'h1, 6'h15, 8'h02);
        chk(spu, 6'h11);
        // Compare and SPI outputs need their pins set as outputs first
        bus(3'h4, 6'h17, 8'h2A);
        @(posedge clk);
        {tce, tc, spe, spv} <= 10'h3A8;
        wt(1);
        chk(fout & foe, 6'h22);
        @(posedge clk);
        tc <= 1'b0;
        ext_val <= 12'hFFE;
        wt(6);
        chk({fout & foe, cap, 1'h0}, 8'h80);
        chk(spil, 4'hD);
        @(posedge clk);
        ext_val <= 12'hFFF;
        pd <= 1'b1;
        wt(6);
        chk(cap, 1'b0);
        rdchk(6'h16, 8'h00);
        rdchk(6'h13, 8'h00);
        @(posedge clk);
        pd <= 1'b0;
        wt(6);
        chk(cap, 1'b1);
        // Outside sources let go; inputs with latch high must still read high through the pull-up
        @(posedge clk);
        ext_en <= 12'h000;
        ext_val <= 12'h000;
        wt(6);
        rdchk(6'h16, 8'h35);
        chk(sout, 6'h31);
        end_sim();
    end
endmodule
`default_nettype wire
